// file: inc/pol_pkg.sv
// polled-output pin logic: shared constants and types
// assumes one 40 MHz core clock; pins are 16 main plus 16 auxiliary
package pol_pkg;
  // ==========================================================
  // pins and groups
  localparam int unsigned NPIN_GRP = 16;
  localparam int unsigned NPIN     = 32;
  localparam int unsigned PIN_IDX_W = 5;
  // ==========================================================
  // poll mode codes (low nibble of mode location)
  localparam logic [3:0] MODE_OFF      = 4'h0;
  localparam logic [3:0] MODE_OUT_CONT = 4'h2;
  localparam logic [3:0] MODE_RUN      = 4'h3;
  localparam logic [3:0] MODE_OUT_RUN  = 4'h4;
  localparam logic [3:0] MODE_OUT_LAT  = 4'hA;
  // ==========================================================
  // status location addresses
  localparam logic [7:0] SPR_STAT_FIRST = 8'h80;
  localparam logic [7:0] SPR_STAT_LAST  = 8'h87;
  localparam logic [7:0] SPR_MODE       = 8'h84;
  localparam logic [7:0] SPR_RUNSLOT    = 8'h85;
  localparam logic [7:0] SPR_GROUP      = 8'h86;
  localparam logic [7:0] SPR_FLAGS      = 8'h87;
  // flag byte bit positions
  localparam int unsigned FB_OUT_EN  = 0;
  localparam int unsigned FB_IN_DEF  = 1;
  localparam int unsigned FB_RUN_EN  = 2;
  localparam int unsigned FB_LATCH   = 3;
  localparam int unsigned FB_TRIG    = 4;
  localparam int unsigned FB_LATCHED = 5;
  localparam int unsigned FB_ACTIVE  = 7;
  // ==========================================================
  // evaluation sequencer
  typedef enum logic [2:0] {
    POL_IDLE = 3'b001,
    POL_EVAL = 3'b010,
    POL_SWCH = 3'b100
  } pol_state_e;
endpackage

// file: core/pol_sync.sv
// polled-output pin logic: three-stage input synchroniser with agreement
// assumes pins are asynchronous to clk_sys
`timescale 1ns/1ps
module pol_sync
  import pol_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            resetn,
  input  wire logic [NPIN-1:0] pin_async,
  output logic      [NPIN-1:0] pin_clean
);
  logic [NPIN-1:0] s1_r, s2_r, s3_r, clean_r, clean_nxt;

  // a change is accepted only once stages two and three agree
  always_comb begin
    clean_nxt = clean_r;
    for (int i = 0; i < NPIN; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        clean_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s1_r    <= '0;
      s2_r    <= '0;
      s3_r    <= '0;
      clean_r <= '0;
    end else begin
      s1_r    <= pin_async;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      clean_r <= clean_nxt;
    end
  end

  assign pin_clean = clean_r;
endmodule

// file: core/pol_out.sv
// polled-output pin logic: polled-input sampling, output drive, status bytes
// assumes the sequencer issues commands as one-cycle strobes and pulses
// insn_done between instructions; scratchpad reads are registered, one cycle behind spr_addr
`timescale 1ns/1ps
module pol_out
  import pol_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  input  wire logic [NPIN-1:0]      pin_in,
  output logic      [NPIN-1:0]      pin_out,
  output logic      [NPIN-1:0]      pin_oe,
  input  wire logic                 insn_done,
  input  wire logic                 define_polled_output_cmd,
  input  wire logic                 define_polled_input_cmd,
  input  wire logic                 poll_mode_select_cmd,
  input  wire logic                 event_slot_switch_cmd,
  input  wire logic                 io_group_sel,
  input  wire logic [3:0]           cmd_pin,
  input  wire logic                 cmd_level,
  input  wire logic [3:0]           cmd_mode,
  input  wire logic [2:0]           cmd_slot,
  input  wire logic [7:0]           spr_addr,
  output logic      [7:0]           spr_rdata,
  output logic                      slot_switch,
  output logic      [2:0]           slot_switch_num,
  output logic                      poll_event
);
  // ==========================================================
  // state
  logic [NPIN-1:0] pin_clean;
  logic [NPIN-1:0] in_def_r, in_def_nxt, in_lvl_r, in_lvl_nxt;
  logic [NPIN-1:0] out_def_r, out_def_nxt, out_lvl_r, out_lvl_nxt;
  logic [NPIN-1:0] drv_r, drv_nxt, oe_r, oe_nxt, trig_r, trig_nxt;
  logic [3:0]      mode_r, mode_nxt;
  logic [2:0]      slot_r, slot_nxt, sw_num_r, sw_num_nxt;
  logic            grp_r, grp_nxt, latched_r, latched_nxt;
  logic            hit_r, hit_nxt, sw_r, sw_nxt, ev_r, ev_nxt;
  logic [7:0]      rdata_r, rdata_nxt;
  pol_state_e      st_r, st_nxt;
  logic [NPIN-1:0] hit_vec;
  logic            out_en, run_en, lat_md, any_hit;

  pol_sync u_sync (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .pin_async (pin_in),
    .pin_clean (pin_clean)
  );

  function automatic logic [PIN_IDX_W-1:0] pin_index(input logic grp, input logic [3:0] p);
    pin_index = {grp, p};
  endfunction

  // ==========================================================
  // mode decode
  always_comb begin
    out_en = (mode_r == MODE_OUT_CONT) || (mode_r == MODE_OUT_RUN) ||
             (mode_r == MODE_OUT_LAT);
    run_en = (mode_r == MODE_RUN) || (mode_r == MODE_OUT_RUN);
    lat_md = (mode_r == MODE_OUT_LAT);
    hit_vec = in_def_r & ~(pin_clean ^ in_lvl_r);
    any_hit = |hit_vec;
  end

  // ==========================================================
  // configuration, sampling and output drive
  always_comb begin
    in_def_nxt  = in_def_r;
    in_lvl_nxt  = in_lvl_r;
    out_def_nxt = out_def_r;
    out_lvl_nxt = out_lvl_r;
    drv_nxt     = drv_r;
    oe_nxt      = oe_r;
    trig_nxt    = trig_r;
    mode_nxt    = mode_r;
    slot_nxt    = slot_r;
    grp_nxt     = io_group_sel;
    latched_nxt = latched_r;
    hit_nxt     = hit_r;
    sw_nxt      = 1'b0;
    sw_num_nxt  = sw_num_r;
    ev_nxt      = 1'b0;
    st_nxt      = st_r;
    // one index per command; any number of pins may accumulate
    if (define_polled_output_cmd) begin
      out_def_nxt[pin_index(grp_r, cmd_pin)] = 1'b1;
      out_lvl_nxt[pin_index(grp_r, cmd_pin)] = cmd_level;
      oe_nxt[pin_index(grp_r, cmd_pin)]      = 1'b1;
      drv_nxt[pin_index(grp_r, cmd_pin)]     = ~cmd_level;
    end
    if (define_polled_input_cmd) begin
      in_def_nxt[pin_index(grp_r, cmd_pin)] = 1'b1;
      in_lvl_nxt[pin_index(grp_r, cmd_pin)] = cmd_level;
      // a polled input releases the pin; its output latch still records state
      oe_nxt[pin_index(grp_r, cmd_pin)]     = 1'b0;
    end
    if (event_slot_switch_cmd) begin
      slot_nxt = cmd_slot;
    end
    if (poll_mode_select_cmd) begin
      mode_nxt    = cmd_mode;
      latched_nxt = 1'b0;
      trig_nxt    = '0;
      hit_nxt     = 1'b0;
      if (cmd_mode == MODE_OFF) begin
        in_def_nxt  = '0;
        out_def_nxt = '0;
      end
    end
    case (st_r)
      POL_IDLE: begin
        if (insn_done) begin
          st_nxt = POL_EVAL;
        end
      end
      POL_EVAL: begin
        st_nxt = POL_IDLE;
        if (out_en || run_en) begin
          // builds on trig_nxt so a mode select in this cycle still clears old bits
          trig_nxt = trig_nxt | hit_vec;
          hit_nxt  = any_hit;
          ev_nxt   = any_hit;
          // every group is scanned so auxiliary outputs respond too
          for (int i = 0; i < NPIN; i++) begin
            if (out_def_r[i] && out_en) begin
              if (lat_md) begin
                if (any_hit) begin
                  drv_nxt[i] = out_lvl_r[i];
                end
              end else begin
                drv_nxt[i] = any_hit ? out_lvl_r[i] : ~out_lvl_r[i];
              end
            end
          end
          if (lat_md && any_hit) begin
            latched_nxt = 1'b1;
          end
          if (run_en && any_hit) begin
            st_nxt = POL_SWCH;
          end
        end
      end
      POL_SWCH: begin
        sw_nxt     = 1'b1;
        sw_num_nxt = slot_r;
        st_nxt     = POL_IDLE;
      end
      default: st_nxt = POL_IDLE;
    endcase
    // a define that lands in an evaluation cycle still starts at the inverse level
    if (define_polled_output_cmd) begin
      drv_nxt[pin_index(grp_r, cmd_pin)] = ~cmd_level;
    end
  end

  // ==========================================================
  // scratchpad status view
  always_comb begin
    rdata_nxt = 8'h00;
    case (spr_addr)
      SPR_STAT_FIRST:        rdata_nxt = trig_r[7:0];
      SPR_STAT_FIRST + 8'h1: rdata_nxt = trig_r[15:8];
      SPR_STAT_FIRST + 8'h2: rdata_nxt = trig_r[23:16];
      SPR_STAT_FIRST + 8'h3: rdata_nxt = trig_r[31:24];
      SPR_MODE:              rdata_nxt = {4'h0, mode_r};
      SPR_RUNSLOT:           rdata_nxt = {5'h00, slot_r};
      SPR_GROUP:             rdata_nxt = {7'h00, grp_r};
      SPR_FLAGS: begin
        rdata_nxt[FB_OUT_EN]  = out_en;
        rdata_nxt[FB_IN_DEF]  = |in_def_r;
        rdata_nxt[FB_RUN_EN]  = run_en;
        rdata_nxt[FB_LATCH]   = lat_md;
        rdata_nxt[FB_TRIG]    = hit_r;
        rdata_nxt[FB_LATCHED] = latched_r;
        rdata_nxt[FB_ACTIVE]  = out_en || run_en;
      end
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      in_def_r  <= '0;
      in_lvl_r  <= '0;
      out_def_r <= '0;
      out_lvl_r <= '0;
      drv_r     <= '0;
      oe_r      <= '0;
      trig_r    <= '0;
      mode_r    <= MODE_OFF;
      slot_r    <= 3'h0;
      grp_r     <= 1'b0;
      latched_r <= 1'b0;
      hit_r     <= 1'b0;
      sw_r      <= 1'b0;
      sw_num_r  <= 3'h0;
      ev_r      <= 1'b0;
      rdata_r   <= 8'h00;
      st_r      <= POL_IDLE;
    end else begin
      in_def_r  <= in_def_nxt;
      in_lvl_r  <= in_lvl_nxt;
      out_def_r <= out_def_nxt;
      out_lvl_r <= out_lvl_nxt;
      drv_r     <= drv_nxt;
      oe_r      <= oe_nxt;
      trig_r    <= trig_nxt;
      mode_r    <= mode_nxt;
      slot_r    <= slot_nxt;
      grp_r     <= grp_nxt;
      latched_r <= latched_nxt;
      hit_r     <= hit_nxt;
      sw_r      <= sw_nxt;
      sw_num_r  <= sw_num_nxt;
      ev_r      <= ev_nxt;
      rdata_r   <= rdata_nxt;
      st_r      <= st_nxt;
    end
  end

  assign pin_out         = drv_r;
  assign pin_oe          = oe_r;
  assign spr_rdata       = rdata_r;
  assign slot_switch     = sw_r;
  assign slot_switch_num = sw_num_r;
  assign poll_event      = ev_r;
endmodule

// file: tb/pol_out_props.sv
// checker for the polled-output pin logic
// assumes the ports of pol_out and one clock domain
`timescale 1ns/1ps
module pol_out_props
  import pol_pkg::*;
(
  input wire logic            clk_sys,
  input wire logic            resetn,
  input wire logic [NPIN-1:0] pin_in,
  input wire logic [NPIN-1:0] pin_out,
  input wire logic [NPIN-1:0] pin_oe,
  input wire logic            insn_done,
  input wire logic            define_polled_output_cmd,
  input wire logic            define_polled_input_cmd,
  input wire logic            poll_mode_select_cmd,
  input wire logic            event_slot_switch_cmd,
  input wire logic            io_group_sel,
  input wire logic [3:0]      cmd_pin,
  input wire logic            cmd_level,
  input wire logic [3:0]      cmd_mode,
  input wire logic [2:0]      cmd_slot,
  input wire logic [7:0]      spr_addr,
  input wire logic [7:0]      spr_rdata,
  input wire logic            slot_switch,
  input wire logic [2:0]      slot_switch_num,
  input wire logic            poll_event
);
  // ========
  // properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [4:0] di;
  assign di = {io_group_sel, cmd_pin};
  // a define beside a group change is left out: the design indexes with the registered group
  a_define_drives_pin: assert property (define_polled_output_cmd && !define_polled_input_cmd
    && !poll_mode_select_cmd && $stable(io_group_sel)
    |=> pin_oe[$past(di)] && (pin_out[$past(di)] != $past(cmd_level)))
    else $error("define did not drive pin at inverse level");
  a_out_needs_cause: assert property ($changed(pin_out) |-> $past(insn_done, 2)
    || $past(define_polled_output_cmd || define_polled_input_cmd || poll_mode_select_cmd))
    else $error("pin_out moved without a boundary or command");
  a_oe_needs_cmd: assert property ($changed(pin_oe) |->
    $past(define_polled_output_cmd || define_polled_input_cmd || poll_mode_select_cmd))
    else $error("pin_oe moved without a command");
  a_event_at_boundary: assert property (poll_event |-> $past(insn_done, 2))
    else $error("poll_event not two cycles after boundary");
  a_event_is_pulse: assert property (poll_event |=> !poll_event)
    else $error("poll_event longer than one cycle");
  a_slot_after_event: assert property (slot_switch |-> $past(poll_event))
    else $error("slot switch not after output update");
  a_unmapped_reads_zero: assert property (spr_addr < SPR_STAT_FIRST
    || spr_addr > SPR_STAT_LAST |=> spr_rdata == 8'h00)
    else $error("unmapped scratchpad not zero");
  a_flag_bit_six: assert property (spr_addr == SPR_FLAGS |=> !spr_rdata[6])
    else $error("flag bit 6 set");
  c_event: cover property (poll_event);
  c_switch: cover property (slot_switch);
  c_define: cover property (define_polled_output_cmd ##1 pin_oe != '0);
endmodule
bind pol_out pol_out_props u_props (
  .clk_sys                  (clk_sys),
  .resetn                   (resetn),
  .pin_in                   (pin_in),
  .pin_out                  (pin_out),
  .pin_oe                   (pin_oe),
  .insn_done                (insn_done),
  .define_polled_output_cmd (define_polled_output_cmd),
  .define_polled_input_cmd  (define_polled_input_cmd),
  .poll_mode_select_cmd     (poll_mode_select_cmd),
  .event_slot_switch_cmd    (event_slot_switch_cmd),
  .io_group_sel             (io_group_sel),
  .cmd_pin                  (cmd_pin),
  .cmd_level                (cmd_level),
  .cmd_mode                 (cmd_mode),
  .cmd_slot                 (cmd_slot),
  .spr_addr                 (spr_addr),
  .spr_rdata                (spr_rdata),
  .slot_switch              (slot_switch),
  .slot_switch_num          (slot_switch_num),
  .poll_event               (poll_event)
);

// file: tb/pol_pins.sv
// external circuits on the pins
// assumes the device drives a pin only while its enable is high
`timescale 1ns/1ps
module pol_pins
  import pol_pkg::*;
(
  input  wire logic [NPIN-1:0] pin_out,
  input  wire logic [NPIN-1:0] pin_oe,
  input  wire logic [NPIN-1:0] ext_lvl,
  output logic      [NPIN-1:0] pin_lvl
);
  // a series resistor is assumed, so the device wins any contention
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

// file: tb/test_polled_output_pin_logic.sv
// self-checking bench for the polled-output pin logic
// assumes pol_out with pol_pins on its pins and the bound checker
`timescale 1ns/1ps
module test_polled_output_pin_logic;
  import pol_pkg::*;
  logic [NPIN-1:0] pin_in, pin_out, pin_oe, ext_lvl = '1;
  logic [NPIN-1:0] act = '0, eo = '0, xo = '0;
  logic            clk_sys = 1'h0, resetn = 1'h0, insn_done = 1'h0;
  logic            define_polled_output_cmd = 1'h0, define_polled_input_cmd = 1'h0;
  logic            poll_mode_select_cmd = 1'h0, event_slot_switch_cmd = 1'h0;
  logic            io_group_sel = 1'h0, cmd_level = 1'h0, slot_switch, poll_event;
  logic            h, seen_ev = 1'h0, seen_sw = 1'h0;
  logic [3:0]      cmd_pin = 4'h0, cmd_mode = 4'h0;
  logic [2:0]      cmd_slot = 3'h0, slot_switch_num, seen_num, s;
  logic [7:0]      spr_addr = 8'h00, spr_rdata;
  int              n_mismatch = 0, n_tests = 0, cyc = 0;
  pol_out  uut (
    .clk_sys                  (clk_sys),
    .resetn                   (resetn),
    .pin_in                   (pin_in),
    .pin_out                  (pin_out),
    .pin_oe                   (pin_oe),
    .insn_done                (insn_done),
    .define_polled_output_cmd (define_polled_output_cmd),
    .define_polled_input_cmd  (define_polled_input_cmd),
    .poll_mode_select_cmd     (poll_mode_select_cmd),
    .event_slot_switch_cmd    (event_slot_switch_cmd),
    .io_group_sel             (io_group_sel),
    .cmd_pin                  (cmd_pin),
    .cmd_level                (cmd_level),
    .cmd_mode                 (cmd_mode),
    .cmd_slot                 (cmd_slot),
    .spr_addr                 (spr_addr),
    .spr_rdata                (spr_rdata),
    .slot_switch              (slot_switch),
    .slot_switch_num          (slot_switch_num),
    .poll_event               (poll_event)
  );
  pol_pins u_pins (.pin_out, .pin_oe, .ext_lvl, .pin_lvl(pin_in));
  always #12.5 clk_sys = ~clk_sys;
  // ========
  // monitors and tasks
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic conclude();
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic cmd(input int k, input logic [3:0] p, input logic l);
    {cmd_pin, cmd_mode, cmd_slot, cmd_level} = {p, p, p[2:0], l};
    {define_polled_output_cmd, define_polled_input_cmd} = {k == 0, k == 1};
    {poll_mode_select_cmd, event_slot_switch_cmd} = {k == 2, k == 3};
    step(1);
    {define_polled_output_cmd, define_polled_input_cmd} = 2'h0;
    {poll_mode_select_cmd, event_slot_switch_cmd} = 2'h0;
    if (k < 2) begin
      {eo[{io_group_sel, p}], act[{io_group_sel, p}]} = {k == 0, l};
      xo[{io_group_sel, p}] = ~l;
    end
    step(1);
  endtask
  // pin 0 is the only polled input and looks for low; other pins get noise
  task automatic poll(input logic hit);
    ext_lvl = {31'($urandom), ~hit};
    step(6);
  endtask
  task automatic tick();
    {seen_ev, seen_sw} = 2'h0;
    insn_done = 1'h1;
    step(1);
    insn_done = 1'h0;
    // pulses stand one cycle, so every settled cycle is looked at
    repeat (4) begin
      step(1);
      seen_ev = seen_ev | (poll_event === 1'h1);
      if (slot_switch === 1'h1) begin
        seen_sw  = 1'h1;
        seen_num = slot_switch_num;
      end
    end
  endtask
  task automatic bnd(input logic upd, input logic hit);
    tick();
    if (upd) xo = hit ? act : ~act;
    chk(pin_out & eo, xo & eo, "pins");
    chk(pin_oe, eo, "oe");
  endtask
  task automatic rd(input logic [7:0] a, m, e);
    spr_addr = a;
    step(1);
    chk(32'(spr_rdata & m), 32'(e), "scratchpad");
  endtask
  // ========
  // main sequence
  initial begin
    void'($urandom(32'h47f8));
    step(16);
    resetn = 1'h1;
    step(1);
    cmd(1, 4'h0, 1'h0);
    cmd(0, 4'h1, 1'h0);
    cmd(0, 4'h2, 1'h1);
    cmd(0, 4'h3, 1'h1);
    cmd(0, 4'h4 + 4'($urandom_range(11)), 1'($urandom));
    io_group_sel = 1'h1;
    step(2);
    cmd(0, 4'($urandom), 1'($urandom));
    chk(pin_oe, eo, "oe after define");
    chk(pin_out & eo, xo & eo, "out after define");
    poll(1'h1);
    bnd(1'h0, 1'h1);
    chk(32'(seen_ev), 32'h0, "event before mode");
    cmd(2, MODE_OUT_CONT, 1'h0);
    for (int i = 0; i < 8; i++) begin
      h = (i < 2) ? 1'(i) : 1'($urandom);
      poll(h);
      chk(pin_out & eo, xo & eo, "held off boundary");
      bnd(1'h1, h);
      chk(32'(seen_ev), 32'(h), "event");
      io_group_sel = ~io_group_sel;
    end
    // a define landing on the evaluation edge beats the active level
    io_group_sel = 1'h0;
    poll(1'h1);
    insn_done = 1'h1;
    step(1);
    {insn_done, xo} = {1'h0, act};
    cmd(0, 4'h1, 1'h0);
    chk(pin_out & eo, xo & eo, "define at evaluation");
    poll(1'h0);
    bnd(1'h1, 1'h0);
    cmd(2, MODE_OUT_LAT, 1'h0);
    bnd(1'h0, 1'h0);
    poll(1'h1);
    bnd(1'h1, 1'h1);
    rd(SPR_FLAGS, 8'hFF, 8'hBB);
    poll(1'h0);
    bnd(1'h0, 1'h0);
    s = 3'($urandom);
    cmd(3, {1'h0, s}, 1'h0);
    cmd(2, MODE_RUN, 1'h0);
    bnd(1'h0, 1'h0);
    poll(1'h1);
    bnd(1'h0, 1'h1);
    chk({seen_sw, seen_num}, {1'h1, s}, "run only switch");
    cmd(2, MODE_OUT_RUN, 1'h0);
    poll(1'h0);
    bnd(1'h1, 1'h0);
    poll(1'h1);
    bnd(1'h1, 1'h1);
    chk({seen_sw, seen_num}, {1'h1, s}, "switch");
    rd(SPR_MODE, 8'h0F, {4'h0, MODE_OUT_RUN});
    rd(SPR_RUNSLOT, 8'h07, {5'h0, s});
    rd(SPR_STAT_FIRST, 8'hFF, 8'h01);
    rd(SPR_GROUP, 8'hFF, {7'h0, io_group_sel});
    rd(SPR_FLAGS, 8'hFF, 8'h97);
    rd(8'h7F, 8'hFF, 8'h00);
    rd(8'h88, 8'hFF, 8'h00);
    cmd(2, MODE_OFF, 1'h0);
    tick();
    chk(32'(seen_ev), 32'h0, "event when off");
    conclude();
  end
endmodule
